// [hw/rmm_pkg.sv]
package rmm_pkg;
	localparam int AW = 8;
	localparam int DW = 8;
	// Region sizes in words. Program region is low, retentive region follows.
	localparam logic [AW-1:0] PROG_WORDS = 8'h40;
	localparam logic [AW-1:0] RET_WORDS = 8'h20;
	localparam logic [AW-1:0] RET_BASE = 8'h40;
	// EEPROM layout: program, retentive copy, backup copy, then marker.
	localparam logic [AW-1:0] EE_RET_BASE = 8'h40;
	localparam logic [AW-1:0] EE_BAK_BASE = 8'h60;
	localparam logic [AW-1:0] EE_MARK_ADDR = 8'h80;
	localparam logic [AW-1:0] ZERO_A = 8'h00;
	localparam logic [AW-1:0] ONE_A = 8'h01;
	localparam logic [DW-1:0] MARK_GOOD = 8'hA5;
	localparam logic [DW-1:0] MARK_CLEAR = 8'h00;

	typedef enum {
		RMM_IDLE, RMM_DL_RAM, RMM_DL_EE, RMM_RUN, RMM_PD_CLR, RMM_PD_SAVE, RMM_PD_MARK,
		RMM_OFF, RMM_PU_MARK, RMM_PU_PROG, RMM_PU_RET
	} rmm_state_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} rmm_mem_req_t;

	typedef struct packed {
		logic valid;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
	} rmm_wr_t;

	typedef struct packed {
		rmm_state_t st;
		logic [AW-1:0] cnt;
		logic [AW-1:0] dl_len;
		logic lost;
		logic use_backup;
		logic major_err;
		logic ready;
		logic [1:0] pfail_sync;
		logic [DW-1:0] rd_data;
		logic rd_valid;
	} rmm_state_reg_t;
endpackage

// [hw/rmm_retentive_memory_manager.sv]
`timescale 1ns/1ps
`default_nettype none
module rmm_retentive_memory_manager (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_fail,
	input wire logic power_up,
	input wire logic go_run,
	input wire rmm_pkg::rmm_wr_t dl_wr,
	input wire logic dl_done,
	input wire rmm_pkg::rmm_wr_t user_wr,
	input wire logic user_rd,
	input wire logic [rmm_pkg::AW-1:0] user_rd_addr,
	output logic [rmm_pkg::DW-1:0] user_rd_data,
	output logic user_rd_valid,
	output logic user_wr_refused,
	output rmm_pkg::rmm_mem_req_t ram,
	input wire logic [rmm_pkg::DW-1:0] ram_rdata,
	output rmm_pkg::rmm_mem_req_t ee,
	input wire logic [rmm_pkg::DW-1:0] ee_rdata,
	output logic running,
	output logic retentive_lost_flag,
	output logic major_error
);
	rmm_pkg::rmm_state_reg_t s_reg;
	rmm_pkg::rmm_state_reg_t s_next;
	logic pf;

	function automatic logic in_ret(input logic [rmm_pkg::AW-1:0] a);
		return (a >= rmm_pkg::RET_BASE) && (a < rmm_pkg::RET_BASE + rmm_pkg::RET_WORDS);
	endfunction

	// The backup block above the retentive copy mirrors the retentive RAM region.
	function automatic logic [rmm_pkg::AW-1:0] dl_copy_src(input logic [rmm_pkg::AW-1:0] a);
		return (a >= rmm_pkg::EE_BAK_BASE) ? a - rmm_pkg::RET_WORDS : a;
	endfunction

	// Power-fail comes from a supply monitor outside the clock domain, so only the second flop is read.
	assign pf = s_reg.pfail_sync[1];

	always_comb begin
		s_next = s_reg;
		s_next.pfail_sync = {s_reg.pfail_sync[0], power_fail};
		s_next.rd_valid = 1'b0;
		ram = '0;
		ee = '0;
		user_wr_refused = 1'b0;
		unique case (s_reg.st)
			rmm_pkg::RMM_IDLE: begin
				if (power_up) begin
					s_next.st = rmm_pkg::RMM_PU_MARK;
					s_next.cnt = rmm_pkg::ZERO_A;
				end else if (dl_wr.valid) begin
					s_next.st = rmm_pkg::RMM_DL_RAM;
				end
			end
			rmm_pkg::RMM_DL_RAM: begin
				ram.req = dl_wr.valid;
				ram.we = 1'b1;
				ram.addr = dl_wr.addr;
				ram.wdata = dl_wr.data;
				if (dl_done) begin
					s_next.st = rmm_pkg::RMM_DL_EE;
					s_next.cnt = rmm_pkg::ZERO_A;
				end
			end
			rmm_pkg::RMM_DL_EE: begin
				// RAM to EEPROM copy
				// RAM data arrives one cycle after its address, so each EEPROM write trails its read by one step.
				ram.req = s_reg.cnt < rmm_pkg::EE_MARK_ADDR;
				ram.addr = dl_copy_src(s_reg.cnt);
				ee.req = s_reg.cnt != rmm_pkg::ZERO_A;
				ee.we = 1'b1;
				ee.addr = s_reg.cnt - rmm_pkg::ONE_A;
				ee.wdata = ram_rdata;
				s_next.cnt = s_reg.cnt + rmm_pkg::ONE_A;
				if (s_reg.cnt == rmm_pkg::EE_MARK_ADDR + rmm_pkg::ONE_A) begin
					ee.addr = rmm_pkg::EE_MARK_ADDR;
					ee.wdata = rmm_pkg::MARK_GOOD;
					s_next.st = rmm_pkg::RMM_RUN;
					s_next.lost = 1'b0;
					s_next.use_backup = 1'b0;
				end
			end
			rmm_pkg::RMM_RUN: begin
				// A read in the same cycle as a write wins; the write is dropped, not queued.
				if (user_rd) begin
					ram.req = 1'b1;
					ram.addr = user_rd_addr;
					s_next.rd_valid = 1'b1;
				end else if (user_wr.valid) begin
					// only retentive writes, only to RAM
					ram.req = in_ret(user_wr.addr);
					ram.we = in_ret(user_wr.addr);
					ram.addr = user_wr.addr;
					ram.wdata = user_wr.data;
					user_wr_refused = !in_ret(user_wr.addr);
				end
				// major error when switched to run while the retentive data came from the backup copy
				if (go_run && s_reg.use_backup)
					s_next.major_err = 1'b1;
				if (pf) begin
					s_next.st = rmm_pkg::RMM_PD_CLR;
					s_next.rd_valid = 1'b0;
				end
			end
			rmm_pkg::RMM_PD_CLR: begin
				// marker cleared first so an interrupted save reads as lost
				ee.req = 1'b1;
				ee.we = 1'b1;
				ee.addr = rmm_pkg::EE_MARK_ADDR;
				ee.wdata = rmm_pkg::MARK_CLEAR;
				s_next.st = rmm_pkg::RMM_PD_SAVE;
				s_next.cnt = rmm_pkg::ZERO_A;
			end
			rmm_pkg::RMM_PD_SAVE: begin
				// retentive region only
				// The EEPROM write trails the RAM read by one cycle, so the region takes one extra step.
				ram.req = s_reg.cnt < rmm_pkg::RET_WORDS;
				ram.addr = rmm_pkg::RET_BASE + s_reg.cnt;
				ee.req = s_reg.cnt != rmm_pkg::ZERO_A;
				ee.we = 1'b1;
				ee.addr = rmm_pkg::EE_RET_BASE + s_reg.cnt - rmm_pkg::ONE_A;
				ee.wdata = ram_rdata;
				s_next.cnt = s_reg.cnt + rmm_pkg::ONE_A;
				if (s_reg.cnt == rmm_pkg::RET_WORDS)
					s_next.st = rmm_pkg::RMM_PD_MARK;
			end
			rmm_pkg::RMM_PD_MARK: begin
				ee.req = 1'b1;
				ee.we = 1'b1;
				ee.addr = rmm_pkg::EE_MARK_ADDR;
				ee.wdata = rmm_pkg::MARK_GOOD;
				s_next.st = rmm_pkg::RMM_OFF;
			end
			rmm_pkg::RMM_OFF: begin
				if (power_up) begin
					s_next.st = rmm_pkg::RMM_PU_MARK;
					s_next.cnt = rmm_pkg::ZERO_A;
				end
			end
			rmm_pkg::RMM_PU_MARK: begin
				// The marker read takes two cycles: the request, then the data that lags it.
				ee.req = 1'b1;
				ee.addr = rmm_pkg::EE_MARK_ADDR;
				if (s_reg.cnt == rmm_pkg::ONE_A) begin
					s_next.use_backup = ee_rdata != rmm_pkg::MARK_GOOD;
					s_next.st = rmm_pkg::RMM_PU_PROG;
					s_next.cnt = rmm_pkg::ZERO_A;
				end else begin
					s_next.cnt = rmm_pkg::ONE_A;
				end
			end
			rmm_pkg::RMM_PU_PROG: begin
				// program before run; EEPROM read data lags one cycle
				ee.req = 1'b1;
				ee.addr = s_reg.cnt;
				ram.req = s_reg.cnt != rmm_pkg::ZERO_A;
				ram.we = 1'b1;
				ram.addr = s_reg.cnt - rmm_pkg::ONE_A;
				ram.wdata = ee_rdata;
				s_next.cnt = s_reg.cnt + rmm_pkg::ONE_A;
				if (s_reg.cnt == rmm_pkg::PROG_WORDS) begin
					ee.req = 1'b0;
					s_next.st = rmm_pkg::RMM_PU_RET;
					s_next.cnt = rmm_pkg::ZERO_A;
				end
			end
			rmm_pkg::RMM_PU_RET: begin
				// retentive from saved or backup copy
				ee.req = 1'b1;
				ee.addr = (s_reg.use_backup ? rmm_pkg::EE_BAK_BASE : rmm_pkg::EE_RET_BASE) + s_reg.cnt;
				ram.req = s_reg.cnt != rmm_pkg::ZERO_A;
				ram.we = 1'b1;
				ram.addr = rmm_pkg::RET_BASE + s_reg.cnt - rmm_pkg::ONE_A;
				ram.wdata = ee_rdata;
				s_next.cnt = s_reg.cnt + rmm_pkg::ONE_A;
				if (s_reg.cnt == rmm_pkg::RET_WORDS) begin
					ee.req = 1'b0;
					s_next.lost = s_reg.use_backup;
					s_next.st = rmm_pkg::RMM_RUN;
				end
			end
			default: s_next.st = rmm_pkg::RMM_IDLE;
		endcase
		// Read data is captured the cycle after the request, while the RAM answer stands.
		if (s_reg.rd_valid)
			s_next.rd_data = ram_rdata;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_reg <= '{st: rmm_pkg::RMM_IDLE, default: '0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign user_rd_data = s_reg.rd_data;
	assign user_rd_valid = s_reg.rd_valid;
	assign running = s_reg.st == rmm_pkg::RMM_RUN;
	assign retentive_lost_flag = s_reg.lost;
	assign major_error = s_reg.major_err;
endmodule // rmm_retentive_memory_manager
`default_nettype wire

// [tb/rmm_asserts.sv]
`timescale 1ns/1ps
`default_nettype none
module rmm_asserts (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic power_fail,
	input wire logic go_run,
	input wire rmm_pkg::rmm_wr_t user_wr,
	input wire logic user_rd,
	input wire logic user_rd_valid,
	input wire logic user_wr_refused,
	input wire rmm_pkg::rmm_mem_req_t ram,
	input wire rmm_pkg::rmm_mem_req_t ee,
	input wire logic running,
	input wire logic retentive_lost_flag,
	input wire logic major_error
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_clr;
		ee.req && ee.we && ee.addr == 8'h80 && ee.wdata == 8'h00;
	endsequence
	sequence s_set;
		ee.req && ee.we && ee.addr == 8'h80 && ee.wdata == 8'hA5;
	endsequence
	AST_MARK_LAST: assert property (s_clr |-> ##34 s_set)
		else $error("marker not set after save");
	AST_PD_REGION: assert property (s_clr |=> (!(ee.req && ee.we) || ee.addr inside {[8'h40:8'h5F]})[*8])
		else $error("save wrote outside retentive");
	AST_RT_EE_QUIET: assert property (running && !power_fail |-> !(ee.req && ee.we))
		else $error("eeprom written at run");
	AST_PROG_RO: assert property (running && !power_fail && user_wr.valid && !user_rd && user_wr.addr < 8'h40
		|-> user_wr_refused && !(ram.req && ram.we))
		else $error("program write not refused");
	AST_RET_WR: assert property (running && !power_fail && user_wr.valid && !user_rd && user_wr.addr inside {[8'h40:8'h5F]}
		|-> ##[0:1] (ram.req && ram.we && ram.addr inside {[8'h40:8'h5F]}))
		else $error("retentive write lost");
	AST_RD_ANS: assert property (running && !power_fail && user_rd |=> user_rd_valid)
		else $error("read not answered");
	AST_ERR_CAUSE: assert property ($rose(major_error) |-> retentive_lost_flag && ($past(go_run) || $past(go_run, 2)))
		else $error("major error without cause");
	AST_FLAG_STEADY: assert property (running && $past(running) |-> $stable(retentive_lost_flag))
		else $error("lost flag moved at run");
endmodule // rmm_asserts
`default_nettype wire

// [tb/rmm_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
module rmm_mem_model (
	input wire logic clk,
	input wire rmm_pkg::rmm_mem_req_t ram,
	input wire rmm_pkg::rmm_mem_req_t ee,
	output logic [7:0] ram_rdata,
	output logic [7:0] ee_rdata
);
	logic [7:0] ram_mem [256];
	logic [7:0] ee_mem [256];
	logic [7:0] ram_q = 8'h00;
	logic [7:0] ee_q = 8'h00;
	assign ram_rdata = ram_q;
	assign ee_rdata = ee_q;
	// Read data holds for one cycle only; it toggles otherwise so a late sample cannot pass.
	always @(posedge clk) begin
		if (ram.req && ram.we) ram_mem[ram.addr] <= ram.wdata;
		if (ee.req && ee.we) ee_mem[ee.addr] <= ee.wdata;
		ram_q <= (ram.req && !ram.we) ? ram_mem[ram.addr] : ~ram_q;
		ee_q <= (ee.req && !ee.we) ? ee_mem[ee.addr] : ~ee_q;
	end
endmodule // rmm_mem_model
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk = 1'b0, rst_b = 1'b0, power_fail = 1'b0, power_up = 1'b0, go_run = 1'b0, dl_done = 1'b0, user_rd = 1'b0;
	rmm_pkg::rmm_wr_t dl_wr = '0, user_wr = '0;
	logic [7:0] user_rd_addr = 8'h00, user_rd_data, ram_rdata, ee_rdata;
	logic user_rd_valid, user_wr_refused, running, retentive_lost_flag, major_error;
	rmm_pkg::rmm_mem_req_t ram, ee;
	int bad_count = 0, compares = 0;
	always #12.5 clk = ~clk;
	rmm_retentive_memory_manager i_rmm_retentive_memory_manager (.clk, .rst_b, .power_fail, .power_up, .go_run,
		.dl_wr, .dl_done, .user_wr, .user_rd, .user_rd_addr, .user_rd_data, .user_rd_valid, .user_wr_refused,
		.ram, .ram_rdata, .ee, .ee_rdata, .running, .retentive_lost_flag, .major_error);
	rmm_mem_model i_rmm_mem_model (.clk, .ram, .ee, .ram_rdata, .ee_rdata);
	function automatic logic [7:0] pat(input logic [7:0] a);
		return a ^ 8'h5A;
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wait_run(input logic v);
		for (int i = 0; i < 400 && running !== v; i++) tick(1);
		chk("running", v, running);
	endtask
	// Power loss wipes the volatile copy, so a restore has to refill it.
	task automatic restart(input bit wipe);
		for (int a = 0; a < 256 && wipe; a++) i_rmm_mem_model.ram_mem[a] = ~pat(a[7:0]);
		power_up = 1'b1;
		tick(1);
		power_up = 1'b0;
		wait_run(1'b1);
	endtask
	task automatic t_download();
		dl_wr = '{1'b1, 8'h00, pat(8'h00)};
		tick(1);
		for (int a = 0; a < 96; a++) begin
			dl_wr = '{1'b1, a[7:0], pat(a[7:0])};
			tick(1);
		end
		dl_wr = '0;
		dl_done = 1'b1;
		tick(1);
		dl_done = 1'b0;
		for (int i = 0; i < 400 && i_rmm_mem_model.ee_mem[8'h7F] !== pat(8'h5F); i++) tick(1);
		chk("ee prog", pat(8'h10), i_rmm_mem_model.ee_mem[8'h10]);
		chk("ee ret", pat(8'h45), i_rmm_mem_model.ee_mem[8'h45]);
		chk("ee bak", pat(8'h45), i_rmm_mem_model.ee_mem[8'h65]);
		chk("ee first", pat(8'h00), i_rmm_mem_model.ee_mem[8'h00]);
		chk("ee bak first", pat(8'h40), i_rmm_mem_model.ee_mem[8'h60]);
	endtask
	task automatic t_run();
		restart(1'b0);
		chk("marker", 8'hA5, i_rmm_mem_model.ee_mem[8'h80]);
		user_wr = '{1'b1, 8'h10, 8'h00};
		#1 chk("refused", 1'b1, user_wr_refused);
		tick(1);
		user_wr = '{1'b1, 8'h45, 8'hC3};
		tick(1);
		user_wr = '0;
		user_rd = 1'b1;
		user_rd_addr = 8'h10;
		tick(1);
		chk("rd valid", 1'b1, user_rd_valid);
		user_rd = 1'b0;
		tick(1);
		chk("rd data", pat(8'h10), user_rd_data);
		chk("ram prog", pat(8'h10), i_rmm_mem_model.ram_mem[8'h10]);
		chk("ram ret", 8'hC3, i_rmm_mem_model.ram_mem[8'h45]);
		chk("ee ret", pat(8'h45), i_rmm_mem_model.ee_mem[8'h45]);
	endtask
	task automatic t_save();
		power_fail = 1'b1;
		wait_run(1'b0);
		tick(40);
		power_fail = 1'b0;
		chk("ee ret", 8'hC3, i_rmm_mem_model.ee_mem[8'h45]);
		chk("ee bak", pat(8'h45), i_rmm_mem_model.ee_mem[8'h65]);
		chk("marker", 8'hA5, i_rmm_mem_model.ee_mem[8'h80]);
		chk("ee ret first", pat(8'h40), i_rmm_mem_model.ee_mem[8'h40]);
		chk("ee ret last", pat(8'h5F), i_rmm_mem_model.ee_mem[8'h5F]);
		restart(1'b1);
		chk("ram prog", pat(8'h10), i_rmm_mem_model.ram_mem[8'h10]);
		chk("ram ret", 8'hC3, i_rmm_mem_model.ram_mem[8'h45]);
		chk("lost", 1'b0, retentive_lost_flag);
		chk("ram prog first", pat(8'h00), i_rmm_mem_model.ram_mem[8'h00]);
		chk("ram ret last", pat(8'h5F), i_rmm_mem_model.ram_mem[8'h5F]);
	endtask
	task automatic t_lost();
		power_fail = 1'b1;
		wait_run(1'b0);
		tick(5);
		rst_b = 1'b0;
		tick(2);
		rst_b = 1'b1;
		power_fail = 1'b0;
		tick(1);
		restart(1'b1);
		chk("lost", 1'b1, retentive_lost_flag);
		chk("ram ret", pat(8'h45), i_rmm_mem_model.ram_mem[8'h45]);
		chk("major", 1'b0, major_error);
		go_run = 1'b1;
		tick(1);
		go_run = 1'b0;
		tick(2);
		chk("major", 1'b1, major_error);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		tick(12);
		rst_b = 1'b1;
		tick(2);
		t_download();
		t_run();
		t_save();
		t_lost();
		tally_and_finish();
	end
	initial begin
		#200us;
		bad_count++;
		tally_and_finish();
	end
endmodule // tb
bind rmm_retentive_memory_manager rmm_asserts i_rmm_asserts (.clk, .rst_b, .power_fail, .go_run, .user_wr, .user_rd,
	.user_rd_valid, .user_wr_refused, .ram, .ee, .running, .retentive_lost_flag, .major_error);
`default_nettype wire
